/* bench/memory_map_router_bench.sv */
// Self-checking bench of the memory map router.
// Assumes the router's package, defines and the SRAM partner model.
`timescale 1ns/1ps
`include "mmr_defs.svh"
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin \
    n_mismatch++; \
    $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g); end end
module memory_map_router_bench;
import mmr_pkg::*;
localparam int MC = `MMR_MC_CLKS;
logic clk_i = 1'b0, resetn_i = 1'b0;
logic [11:0] awaddr, araddr;
logic awvalid, wvalid, bready, arvalid, rready, awready, wready;
logic bvalid, arready, rvalid, freq, fint, fext, fstb_n;
logic xreq, busy, done, err, rd_n, wr_n, bmode, p0l;
logic fext_nr, p0l_nr;
logic [31:0] wdata, rdata, rd_q, seed = 32'h10ae_9ae9;
logic [1:0] bresp, rresp, br_q, rr_q;
logic [15:0] faddr, rvec;
logic [7:0] xrd, ext_rdata, scb, ext_val;
mmr_xreq_t xd;
int n_mismatch = 0, n_tests = 0, cyc = 0;
logic [15:0] ad [4];
logic [7:0] dd [4];
mmr_router u_dut (.clk_i(clk_i), .resetn_i(resetn_i),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
    .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
    .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
    .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
    .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
    .s_axi_rready_i(rready), .fetch_req_i(freq), .fetch_addr_i(faddr),
    .fetch_int_o(fint), .fetch_ext_o(fext),
    .code_fetch_strobe_n_o(fstb_n), .reset_vector_o(rvec),
    .xdata_req_i(xreq), .xdata_i(xd), .xdata_busy_o(busy),
    .xdata_done_o(done), .xdata_err_o(err), .xdata_rdata_o(xrd),
    .rd_n_o(rd_n), .wr_n_o(wr_n), .ext_rdata_i(ext_rdata), .scb_i(scb),
    .bus_mode_o(bmode), .port0_latch_o(p0l));
mmr_ext_mem u_mem (.clk_i(clk_i), .rd_n_i(rd_n), .value_i(ext_val),
    .data_o(ext_rdata));
// Variant without code memory: every fetch must leave on the bus
mmr_router #(.HAS_ROM(1'b0)) u_dut_norom (.clk_i(clk_i),
    .resetn_i(resetn_i), .s_axi_awaddr_i(awaddr),
    .s_axi_awvalid_i(awvalid), .s_axi_awready_o(),
    .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hf),
    .s_axi_wvalid_i(wvalid), .s_axi_wready_o(), .s_axi_bresp_o(),
    .s_axi_bvalid_o(), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(), .s_axi_rdata_o(), .s_axi_rresp_o(),
    .s_axi_rvalid_o(), .s_axi_rready_i(rready), .fetch_req_i(freq),
    .fetch_addr_i(faddr), .fetch_int_o(), .fetch_ext_o(fext_nr),
    .code_fetch_strobe_n_o(), .reset_vector_o(), .xdata_req_i(xreq),
    .xdata_i(xd), .xdata_busy_o(), .xdata_done_o(), .xdata_err_o(),
    .xdata_rdata_o(), .rd_n_o(), .wr_n_o(), .ext_rdata_i(ext_rdata),
    .scb_i(scb), .bus_mode_o(), .port0_latch_o(p0l_nr));
// ****************************************************************
// Helpers
// ****************************************************************
function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
endfunction
function automatic logic [16:0] rom_size(input logic [2:0] c);
    return (c == 3'h0) ? 17'h0_0000 : (17'h0_0400 << (c - 3'h1));
endfunction
task automatic complete_run();
    $display("mismatches %0d, comparisons %0d", n_mismatch, n_tests);
    if (n_mismatch == 0 && n_tests > 0) begin
        $display("RESULT: PASS");
    end else begin
        $display("RESULT: FAIL");
    end
    $finish;
endtask
// Ready is looked at on the falling edge, where it has settled
task automatic axi_wr(input logic [11:0] a, input logic [7:0] d);
    logic aw, w, b;
    b = 1'b0;
    seed = lfsr(seed);
    @(posedge clk_i);
    awaddr <= a;
    wdata <= {seed[31:8], d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!b) begin
        @(negedge clk_i);
        aw = awvalid && awready;
        w = wvalid && wready;
        b = (bvalid === 1'b1);
        br_q = bresp;
        @(posedge clk_i);
        if (aw) awvalid <= 1'b0;
        if (w) wvalid <= 1'b0;
        if (b) bready <= 1'b0;
    end
    `CHK("bresp", `MMR_RESP_OKAY, br_q)
endtask
task automatic axi_rd(input logic [11:0] a);
    logic ar, r;
    r = 1'b0;
    @(posedge clk_i);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!r) begin
        @(negedge clk_i);
        ar = arvalid && arready;
        r = (rvalid === 1'b1);
        rd_q = rdata;
        rr_q = rresp;
        @(posedge clk_i);
        if (ar) arvalid <= 1'b0;
        if (r) rready <= 1'b0;
    end
endtask
task automatic rd_chk(input logic [11:0] a, input logic [7:0] e);
    axi_rd(a);
    `CHK("register read", {24'h00_0000, e}, rd_q)
endtask
task automatic set_lim(input logic [2:0] c);
    axi_wr(`MMR_ADDR_KEY, `MMR_KEY_FIRST);
    axi_wr(`MMR_ADDR_KEY, `MMR_KEY_SECOND);
    // No fetch is in flight while the map changes
    axi_wr(`MMR_ADDR_LIM, {5'h00, c});
    repeat (2 * MC) @(posedge clk_i);
endtask
// Back-to-back fetches at the limit edge, in the vectors and at random
task automatic fetch_run(input int n, input logic [2:0] c);
    logic [16:0] sz;
    logic [15:0] a;
    logic pe;
    sz = rom_size(c);
    pe = 1'b0;
    for (int i = 0; i <= n; i++) begin
        seed = lfsr(seed);
        case (i % 4)
            0: a = sz[15:0] - 16'h0001;
            1: a = sz[15:0];
            2: a = seed[15:0] & 16'h03ff;
            default: a = seed[15:0];
        endcase
        @(posedge clk_i);
        freq <= (i < n);
        faddr <= a;
        @(negedge clk_i);
        if (i > 0) begin
            `CHK("fetch internal", pe, fint)
            `CHK("fetch external", !pe, fext)
            `CHK("fetch strobe", pe, fstb_n)
            `CHK("bus mode fetch", !pe, bmode)
            `CHK("no-rom fetch", 1'b1, fext_nr)
        end
        pe = ({1'b0, a} < sz);
    end
endtask
task automatic xmove(input logic we, input logic [15:0] a,
    input logic [7:0] wd, input logic ext, input logic er,
    input logic [7:0] rd);
    int n;
    n = 0;
    @(posedge clk_i);
    xreq <= 1'b1;
    xd <= '{we: we, addr: a, wdata: wd};
    @(posedge clk_i);
    xreq <= 1'b0;
    @(negedge clk_i);
    if (ext) `CHK("busy", 1'b1, busy)
    `CHK("bus mode move", ext, bmode)
    `CHK("read strobe", !(ext && !we), rd_n)
    `CHK("write strobe", !(ext && we), wr_n)
    while (done !== 1'b1 && n < 20) begin
        @(negedge clk_i);
        n++;
    end
    `CHK("move done", 1'b1, done)
    if (!ext && !er) `CHK("internal time", 1'b1, n <= 2 * MC)
    `CHK("move error", er, err)
    if (!we) `CHK("move data", rd, xrd)
    @(negedge clk_i);
    `CHK("done pulse", 1'b0, done)
endtask
// ****************************************************************
// Sequence
// ****************************************************************
initial begin
    forever #25 clk_i = ~clk_i;
end
always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
        n_mismatch++;
        complete_run();
    end
end
initial begin
    {awvalid, wvalid, bready, arvalid, rready, freq, xreq} = 7'h00;
    awaddr = 12'h000;
    araddr = 12'h000;
    wdata = 32'h0000_0000;
    faddr = 16'h0000;
    xd = '0;
    scb = seed[7:0];
    ext_val = seed[15:8];
    repeat (10) @(posedge clk_i);
    resetn_i <= 1'b1;
    @(negedge clk_i);
    `CHK("reset vector", `MMR_RESET_VEC, rvec)
    `CHK("port0 latch", 1'b1, p0l)
    `CHK("no-rom latch", 1'b0, p0l_nr)
    rd_chk(`MMR_ADDR_MCFG, 8'h00);
    rd_chk(`MMR_ADDR_LIM, 8'h07);
    axi_rd(12'h004);
    `CHK("unmapped resp", `MMR_RESP_SLVERR, rr_q)
    `CHK("unmapped data", 32'h0000_0000, rd_q)
    fetch_run(8, 3'h7);
    for (int c = 0; c < 8; c++) begin
        set_lim(3'(c));
        rd_chk(`MMR_ADDR_LIM, 8'(c));
        fetch_run(12, 3'(c));
    end
    axi_wr(`MMR_ADDR_LIM, 8'h03);
    rd_chk(`MMR_ADDR_LIM, 8'h07);
    axi_wr(`MMR_ADDR_KEY, `MMR_KEY_FIRST);
    axi_wr(`MMR_ADDR_KEY, `MMR_KEY_SECOND);
    axi_wr(`MMR_ADDR_MCFG, 8'h00);
    axi_wr(`MMR_ADDR_LIM, 8'h03);
    rd_chk(`MMR_ADDR_LIM, 8'h07);
    axi_wr(`MMR_ADDR_KEY, `MMR_KEY_FIRST);
    axi_wr(`MMR_ADDR_KEY, `MMR_KEY_SECOND);
    rd_chk(`MMR_ADDR_STAT, 8'h01);
    rd_chk(`MMR_ADDR_KEY, 8'h00);
    set_lim(3'h2);
    rd_chk(`MMR_ADDR_LIM, 8'h02);
    fetch_run(8, 3'h2);
    xmove(1'b0, 16'h0123, 8'h00, 1'b1, 1'b0, ext_val);
    xmove(1'b1, 16'h0200, 8'h5a, 1'b1, 1'b0, 8'h00);
    axi_wr(`MMR_ADDR_MCFG, 8'h01);
    for (int i = 0; i < 4; i++) begin
        seed = lfsr(seed);
        ad[i] = (i == 3) ? 16'h03ff : {6'h00, 2'(i), seed[7:0]};
        dd[i] = seed[15:8];
        xmove(1'b1, ad[i], dd[i], 1'b0, 1'b0, 8'h00);
    end
    xmove(1'b0, 16'h0400, 8'h00, 1'b1, 1'b0, ext_val);
    axi_wr(`MMR_ADDR_MCFG, 8'h00);
    xmove(1'b0, ad[0], 8'h00, 1'b1, 1'b0, ext_val);
    axi_wr(`MMR_ADDR_MCFG, 8'h03);
    xmove(1'b0, `MMR_SCB_ADDR, 8'h00, 1'b0, 1'b0, scb);
    xmove(1'b1, `MMR_SCB_ADDR, 8'h11, 1'b0, 1'b1, 8'h00);
    xmove(1'b0, 16'h0400, 8'h00, 1'b0, 1'b1, 8'h00);
    for (int i = 0; i < 4; i++) begin
        xmove(1'b0, ad[i], 8'h00, 1'b0, 1'b0, dd[i]);
    end
    axi_wr(`MMR_ADDR_MCFG, 8'h02);
    xmove(1'b0, 16'h0000, 8'h00, 1'b0, 1'b1, 8'h00);
    @(posedge clk_i);
    resetn_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    resetn_i <= 1'b1;
    rd_chk(`MMR_ADDR_LIM, 8'h07);
    rd_chk(`MMR_ADDR_MCFG, 8'h00);
    fetch_run(4, 3'h7);
    xmove(1'b0, ad[1], 8'h00, 1'b1, 1'b0, ext_val);
    complete_run();
end
endmodule

/* bench/mmr_ext_mem.sv */
// External SRAM partner of the memory map router bench.
// Assumes the router's active-low read strobe and a shared clock.
`timescale 1ns/1ps
module mmr_ext_mem (
    input wire logic clk_i,
    input wire logic rd_n_i,
    input wire logic [7:0] value_i,
    output logic [7:0] data_o
);
    logic [7:0] last;
    initial last = 8'h00;
    always @(posedge clk_i) begin
        if (!rd_n_i) begin
            last <= value_i;
        end
    end
    // Released bus shows the inverse, so a stale byte can never match
    // The bus pins carry memory traffic only, never port I/O
    assign data_o = !rd_n_i ? value_i : ~last;
endmodule

/* pkg/mmr_defs.svh */
// Offsets, field positions, reset values and timing counts of the
// memory map router. Included by the router and by any bench.
`ifndef MMR_DEFS_SVH
`define MMR_DEFS_SVH
// Register indices; the byte address on the bus is four times the index
`define MMR_IDX_KEY 8'hC7
`define MMR_IDX_MCFG 8'hC4
`define MMR_IDX_LIM 8'hC2
`define MMR_IDX_STAT 8'hC0
`define MMR_ADDR_KEY 12'h31C
`define MMR_ADDR_MCFG 12'h310
`define MMR_ADDR_LIM 12'h308
`define MMR_ADDR_STAT 12'h300
// Field positions
`define MMR_DME_MSB 1
`define MMR_LIM_MSB 2
// Reset values and key bytes
`define MMR_DME_RST 2'h0
`define MMR_LIM_MAX 3'h7
`define MMR_RESET_VEC 16'h0000
`define MMR_KEY_FIRST 8'hAA
`define MMR_KEY_SECOND 8'h55
// Data map
`define MMR_XRAM_TOP 16'h03FF
`define MMR_XRAM_WORDS 1024
`define MMR_SCB_ADDR 16'hFFFC
`define MMR_VEC_TOP 16'h03FF
`define MMR_ROM_UNIT 17'h0_0400
// Timing: clocks per machine cycle, machine cycles per access
`define MMR_MC_CLKS 4
`define MMR_INT_MC 2
`define MMR_EXT_MC 1
// Bus responses
`define MMR_RESP_OKAY 2'h0
`define MMR_RESP_SLVERR 2'h2
`endif

/* pkg/mmr_pkg.sv */
// Types shared by the memory map router and its bench.
// Assumes nothing of its surroundings.
package mmr_pkg;
    typedef enum logic [1:0] {KEY_IDLE, KEY_GOT_AA, KEY_ARMED} mmr_key_t;
    typedef enum logic [1:0] {XS_IDLE, XS_INT, XS_EXT} mmr_xstate_t;
    typedef enum logic [1:0] {RT_INT, RT_EXT, RT_SCB, RT_NONE} mmr_route_t;
    typedef struct packed {
        logic we;
        logic [15:0] addr;
        logic [7:0] wdata;
    } mmr_xreq_t;
endpackage

/* rtl/mmr_router.sv */
// Memory map router: steers code fetches and external-data moves to
// on-chip memory or to the expanded bus, with an AXI4-Lite register slave.
// Assumes the core, the bus and the external-bus unit share clk_i.
//
// How it works
// - Accesses beyond on-chip memory, or with none present, go to the bus; in the reserved and SCB data maps they are refused, SCB reads in the SCB map apart.
// - Ports 0 and 2 are flagged as bus, not I/O, during bus traffic.
// - External code fetches drive the fetch strobe low.
// - Without on-chip code, all fetches go out and port 0 has no latch.
// - Off-chip data moves use the read and write strobes as enables.
// - After any reset fetching starts at 0000h.
// - First fetch is internal when code memory exists, else external.
// - On-chip code is contiguous from 0000h up to the selected size.
// - On-chip data RAM is contiguous from 0000h, apart from scratchpad.
// - Data moves hitting on-chip RAM finish within two machine cycles.
// - After reset the data RAM is hidden; all data moves go out.
// - Data RAM enable bits are bits 1-0 and clear on reset.
// - Enable field picks external, low 1kB internal, reserved, or SCB map.
// - Changing the enable bits leaves data RAM contents untouched.
// - Three-bit limit selects 0 to 64 kB; above it goes off-chip.
// - Reset loads the limit with the variant's largest size.
// - Zero limit sends vector-table fetches to external memory.
//
// Implementation choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "mmr_defs.svh"
module mmr_router #(
    parameter bit HAS_ROM = 1'b1,
    parameter logic [2:0] ROM_MAX = `MMR_LIM_MAX,
    parameter int MC_CLKS = `MMR_MC_CLKS
) (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic [11:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic [11:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    input wire logic fetch_req_i,
    input wire logic [15:0] fetch_addr_i,
    output logic fetch_int_o,
    output logic fetch_ext_o,
    output logic code_fetch_strobe_n_o,
    output logic [15:0] reset_vector_o,
    input wire logic xdata_req_i,
    input wire mmr_pkg::mmr_xreq_t xdata_i,
    output logic xdata_busy_o,
    output logic xdata_done_o,
    output logic xdata_err_o,
    output logic [7:0] xdata_rdata_o,
    output logic rd_n_o,
    output logic wr_n_o,
    input wire logic [7:0] ext_rdata_i,
    input wire logic [7:0] scb_i,
    output logic bus_mode_o,
    output logic port0_latch_o
);
    import mmr_pkg::*;

    localparam int INT_CLKS = `MMR_INT_MC * MC_CLKS;
    localparam int EXT_CLKS = `MMR_EXT_MC * MC_CLKS;
    localparam logic [7:0] INT_LAST = 8'(INT_CLKS - 1);
    localparam logic [7:0] EXT_LAST = 8'(EXT_CLKS - 1);
    localparam logic [2:0] LIM_RST = HAS_ROM ? ROM_MAX : 3'h0;

    // Size in bytes selected by a limit code
    function automatic logic [16:0] size_of(input logic [2:0] c);
        size_of = (c == 3'h0) ? 17'h0_0000 :
                  (`MMR_ROM_UNIT << (c - 3'h1));
    endfunction

    // ********************************************************
    // Register slave
    // ********************************************************
    logic awh, next_awh, wh, next_wh, wsel, next_wsel;
    logic [11:0] awa, next_awa;
    logic [7:0] wd, next_wd;
    logic bv, next_bv, rv, next_rv;
    logic [1:0] br, next_br, rr, next_rr;
    logic [31:0] rd, next_rd;
    mmr_key_t key, next_key;
    logic [1:0] dme, next_dme;
    logic [2:0] lim, next_lim;
    mmr_xstate_t xs, next_xs;
    logic fext, fint;

    assign s_axi_awready_o = !awh && !bv;
    assign s_axi_wready_o = !wh && !bv;
    assign s_axi_arready_o = !rv;
    assign s_axi_bvalid_o = bv;
    assign s_axi_bresp_o = br;
    assign s_axi_rvalid_o = rv;
    assign s_axi_rresp_o = rr;
    assign s_axi_rdata_o = rd;

    always_comb begin
        next_awh = awh;
        next_awa = awa;
        next_wh = wh;
        next_wd = wd;
        next_wsel = wsel;
        next_bv = bv;
        next_br = br;
        next_rv = rv;
        next_rr = rr;
        next_rd = rd;
        next_key = key;
        next_dme = dme;
        next_lim = lim;
        if (s_axi_awvalid_i && s_axi_awready_o) begin
            next_awh = 1'b1;
            next_awa = s_axi_awaddr_i;
        end
        if (s_axi_wvalid_i && s_axi_wready_o) begin
            next_wh = 1'b1;
            next_wd = s_axi_wdata_i[7:0];
            next_wsel = s_axi_wstrb_i[0];
        end
        if (bv && s_axi_bready_i) begin
            next_bv = 1'b0;
        end
        if (awh && wh) begin
            next_awh = 1'b0;
            next_wh = 1'b0;
            next_bv = 1'b1;
            next_br = `MMR_RESP_OKAY;
            unique case (awa)
                `MMR_ADDR_KEY: begin
                    if (wsel && wd == `MMR_KEY_FIRST) begin
                        next_key = KEY_GOT_AA;
                    end else if (wsel && wd == `MMR_KEY_SECOND &&
                                 key == KEY_GOT_AA) begin
                        next_key = KEY_ARMED;
                    end else if (wsel) begin
                        next_key = KEY_IDLE;
                    end
                end
                `MMR_ADDR_MCFG: begin
                    if (wsel) begin
                        next_dme = wd[`MMR_DME_MSB:0];
                        next_key = KEY_IDLE;
                    end
                end
                `MMR_ADDR_LIM: begin
                    if (wsel) begin
                        next_key = KEY_IDLE;
                        // A limit above the variant's memory is clamped
                        if (HAS_ROM && key == KEY_ARMED) begin
                            next_lim = (wd[`MMR_LIM_MSB:0] > ROM_MAX) ?
                                       ROM_MAX : wd[`MMR_LIM_MSB:0];
                        end
                    end
                end
                `MMR_ADDR_STAT: begin
                    if (wsel) begin
                        next_key = KEY_IDLE;
                    end
                end
                default: begin
                    next_br = `MMR_RESP_SLVERR;
                end
            endcase
        end
        if (rv && s_axi_rready_i) begin
            next_rv = 1'b0;
        end
        if (s_axi_arvalid_i && s_axi_arready_o) begin
            next_rv = 1'b1;
            next_rr = `MMR_RESP_OKAY;
            unique case (s_axi_araddr_i)
                `MMR_ADDR_KEY: next_rd = 32'h0000_0000;
                `MMR_ADDR_MCFG: next_rd = {30'h0000_0000, dme};
                `MMR_ADDR_LIM: next_rd = {29'h0000_0000, lim};
                `MMR_ADDR_STAT: next_rd = {28'h000_0000, fext,
                    xs == XS_EXT, xs != XS_IDLE, key == KEY_ARMED};
                default: begin
                    next_rd = 32'h0000_0000;
                    next_rr = `MMR_RESP_SLVERR;
                end
            endcase
        end
    end

    // Any reset clears the data enables and restores the full limit
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            awh <= 1'b0;
            awa <= 12'h000;
            wh <= 1'b0;
            wd <= 8'h00;
            wsel <= 1'b0;
            bv <= 1'b0;
            br <= `MMR_RESP_OKAY;
            rv <= 1'b0;
            rr <= `MMR_RESP_OKAY;
            rd <= 32'h0000_0000;
            key <= KEY_IDLE;
            dme <= `MMR_DME_RST;
            lim <= LIM_RST;
        end else begin
            awh <= next_awh;
            awa <= next_awa;
            wh <= next_wh;
            wd <= next_wd;
            wsel <= next_wsel;
            bv <= next_bv;
            br <= next_br;
            rv <= next_rv;
            rr <= next_rr;
            rd <= next_rd;
            key <= next_key;
            dme <= next_dme;
            lim <= next_lim;
        end
    end

    // ********************************************************
    // Code fetch routing
    // ********************************************************
    logic in_rom, next_fint, next_fext;

    // The vector table sits below 1kB, so a zero limit sends it out
    assign in_rom = HAS_ROM &&
                    ({1'b0, fetch_addr_i} < size_of(lim));

    always_comb begin
        next_fint = fetch_req_i && in_rom;
        next_fext = fetch_req_i && !in_rom;
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            fint <= 1'b0;
            fext <= 1'b0;
        end else begin
            fint <= next_fint;
            fext <= next_fext;
        end
    end

    assign fetch_int_o = fint;
    assign fetch_ext_o = fext;
    assign code_fetch_strobe_n_o = !fext;
    assign reset_vector_o = `MMR_RESET_VEC;
    assign port0_latch_o = HAS_ROM;

    // ********************************************************
    // External-data routing
    // ********************************************************
    logic [7:0] ram [`MMR_XRAM_WORDS];
    logic [7:0] ext_q1, ext_q2;
    mmr_route_t route;
    mmr_xreq_t xr, next_xr;
    logic [7:0] cnt, next_cnt, xrd, next_xrd;
    logic done, next_done, err, next_err;

    always_comb begin
        route = RT_EXT;
        unique case (dme)
            2'h1: route = (xdata_i.addr <= `MMR_XRAM_TOP) ?
                          RT_INT : RT_EXT;
            2'h2: route = RT_NONE;
            2'h3: begin
                if (xdata_i.addr <= `MMR_XRAM_TOP) begin
                    route = RT_INT;
                end else if (xdata_i.addr == `MMR_SCB_ADDR &&
                             !xdata_i.we) begin
                    route = RT_SCB;
                end else begin
                    route = RT_NONE;
                end
            end
            default: route = RT_EXT;
        endcase
    end

    always_comb begin
        next_xs = xs;
        next_xr = xr;
        next_cnt = cnt;
        next_xrd = xrd;
        next_done = 1'b0;
        next_err = 1'b0;
        unique case (xs)
            XS_IDLE: begin
                if (xdata_req_i) begin
                    next_xr = xdata_i;
                    next_cnt = 8'h00;
                    unique case (route)
                        RT_INT: next_xs = XS_INT;
                        RT_EXT: next_xs = XS_EXT;
                        RT_SCB: begin
                            next_xrd = scb_i;
                            next_done = 1'b1;
                        end
                        RT_NONE: begin
                            // Reserved space: no access, flagged
                            next_xrd = 8'h00;
                            next_done = 1'b1;
                            next_err = 1'b1;
                        end
                    endcase
                end
            end
            XS_INT: begin
                next_cnt = cnt + 8'h01;
                if (cnt == INT_LAST) begin
                    next_xs = XS_IDLE;
                    next_done = 1'b1;
                    next_xrd = xr.we ? xrd : ram[xr.addr[9:0]];
                end
            end
            XS_EXT: begin
                next_cnt = cnt + 8'h01;
                if (cnt == EXT_LAST) begin
                    next_xs = XS_IDLE;
                    next_done = 1'b1;
                    next_xrd = xr.we ? xrd : ext_q2;
                end
            end
            default: next_xs = XS_IDLE;
        endcase
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            xs <= XS_IDLE;
            xr <= '0;
            cnt <= 8'h00;
            xrd <= 8'h00;
            done <= 1'b0;
            err <= 1'b0;
            ext_q1 <= 8'h00;
            ext_q2 <= 8'h00;
        end else begin
            xs <= next_xs;
            xr <= next_xr;
            cnt <= next_cnt;
            xrd <= next_xrd;
            done <= next_done;
            err <= next_err;
            ext_q1 <= ext_rdata_i;
            ext_q2 <= ext_q1;
        end
    end

    // Only data moves write the RAM; the enable bits never touch it
    always_ff @(posedge clk_i) begin
        if (xs == XS_INT && cnt == INT_LAST && xr.we) begin
            ram[xr.addr[9:0]] <= xr.wdata;
        end
    end

    assign xdata_busy_o = xs != XS_IDLE;
    assign xdata_done_o = done;
    assign xdata_err_o = err;
    assign xdata_rdata_o = xrd;
    assign rd_n_o = !(xs == XS_EXT && !xr.we);
    assign wr_n_o = !(xs == XS_EXT && xr.we);
    assign bus_mode_o = fext || xs == XS_EXT;

    // ********************************************************
    // Checks
    // ********************************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);

    a_ext_fetch: assert property (fetch_req_i &&
        ({1'b0, fetch_addr_i} >= size_of(lim)) |=>
        fetch_ext_o && !code_fetch_strobe_n_o && bus_mode_o)
        else $error("External fetch not routed to the bus");
    a_rom_fetch: assert property (HAS_ROM && fetch_req_i &&
        ({1'b0, fetch_addr_i} < size_of(lim)) |=>
        fetch_int_o && code_fetch_strobe_n_o)
        else $error("On-chip fetch routed wrongly");
    a_vector_out: assert property (lim == 3'h0 && fetch_req_i &&
        fetch_addr_i <= `MMR_VEC_TOP |=> fetch_ext_o)
        else $error("Vector fetch kept on-chip at zero limit");
    a_no_rom: assert property (!HAS_ROM && fetch_req_i |=>
        fetch_ext_o && !port0_latch_o)
        else $error("Variant without code memory fetched on-chip");
    a_ram_latency: assert property (xs == XS_IDLE && xdata_req_i &&
        route == RT_INT |=> xs == XS_INT ##[1:8] xdata_done_o)
        else $error("On-chip data move took too long");
    a_hidden_ram: assert property (dme == 2'h0 && xs == XS_IDLE &&
        xdata_req_i |=> xs == XS_EXT && bus_mode_o)
        else $error("Data move not sent out with RAM hidden");
    a_map_reserved: assert property (dme == 2'h2 && xs == XS_IDLE &&
        xdata_req_i |=> xdata_done_o && xdata_err_o)
        else $error("Reserved data map not refused");
    a_scb_read: assert property (dme == 2'h3 && xs == XS_IDLE &&
        xdata_req_i && xdata_i.addr == `MMR_SCB_ADDR && !xdata_i.we
        |=> xdata_done_o && xdata_rdata_o == $past(scb_i))
        else $error("System control byte read wrong");
    a_strobe_bus: assert property (!rd_n_o || !wr_n_o |->
        bus_mode_o && xs == XS_EXT)
        else $error("Data strobe outside an external move");
    a_limit_key: assert property (lim != $past(lim) |->
        $past(key) == KEY_ARMED)
        else $error("Limit changed without the key sequence");
endmodule
